// File: hw/pbbs_core.sv
// pixel balance and bit shift datapath stage
`default_nettype none

// Function
// - separate red, green, blue ratios, selector addressed
// - ratio one passes intensity unchanged
// - intensity multiplied proportionally by ratio
// - ratios accepted from 0.00 to 3.98
// - ratio below one lowers reachable maximum
// - input samples are twelve bit converter codes
// - shift zero outputs all twelve bits
// - shift one outputs bits 10..0 plus zero
// - shift two outputs bits 9..0 plus zeros
// - shift three outputs bits 8..0 plus zeros
// - shift four outputs bits 7..0 plus zeros
// - shift one, bit 11 set saturates
// - shift two, bits 11..10 saturate
// - shift three, bits 11..9 saturate
// - shift four, bits 11..8 saturate
// - shift zero disables, one to four shift
module pbbs_core (
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  input wire logic i_color_en,
  input wire logic i_cfa_row_rb,
  input wire logic i_ratio_wr,
  input wire logic [1:0] i_ratio_sel,
  input wire logic [8:0] i_ratio_wdata,
  input wire logic [2:0] i_shift,
  input wire logic i_pix_valid,
  input wire logic i_pix_sol,
  input wire logic i_pix_sof,
  input wire logic [11:0] i_pix_data,
  output logic [8:0] o_ratio_rdata,
  output logic o_ratio_err,
  output logic o_pix_valid,
  output logic [11:0] o_pix_data,
  output logic o_pix_sat
);

  // ----------------------------------------------------------------
  // ratio storage
  // ----------------------------------------------------------------
  logic [8:0] ratio_r [3];
  logic [8:0] ratio_nxt [3];
  logic [8:0] rdata_r;
  logic [8:0] rdata_nxt;
  logic err_r;
  logic err_nxt;
  logic [1:0] sel_idx;
  logic sel_ok;

  always_comb
  begin
    sel_ok = 1'b1;
    unique case (i_ratio_sel)
      pbbs_pkg::PBBS_CH_RED: sel_idx = 2'h0;
      pbbs_pkg::PBBS_CH_GREEN: sel_idx = 2'h1;
      pbbs_pkg::PBBS_CH_BLUE: sel_idx = 2'h2;
      default:
      begin
        sel_idx = 2'h0;
        sel_ok = 1'b0;
      end
    endcase
  end

  genvar gc;
  generate
    for (gc = 0; gc < 3; gc++)
    begin : g_ratio
      always_comb
      begin
        ratio_nxt[gc] = ratio_r[gc];
        // out of range or bad selector writes are dropped
        if (i_ratio_wr && sel_ok && (sel_idx == 2'(gc)) &&
            (i_ratio_wdata <= pbbs_pkg::RATIO_MAX))
        begin
          ratio_nxt[gc] = i_ratio_wdata;
        end
      end
      always_ff @(posedge i_sys_clk or negedge i_nrst)
      begin
        if (!i_nrst)
        begin
          ratio_r[gc] <= pbbs_pkg::RATIO_ONE;
        end
        else if (i_ce)
        begin
          ratio_r[gc] <= ratio_nxt[gc];
        end
      end
    end
  endgenerate

  always_comb
  begin
    rdata_nxt = sel_ok ? ratio_r[sel_idx] : 9'h000;
    err_nxt = err_r;
    if (i_ratio_wr)
    begin
      err_nxt = !sel_ok || (i_ratio_wdata > pbbs_pkg::RATIO_MAX);
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      rdata_r <= pbbs_pkg::RATIO_ONE;
      err_r <= 1'b0;
    end
    else if (i_ce)
    begin
      rdata_r <= rdata_nxt;
      err_r <= err_nxt;
    end
  end

  assign o_ratio_rdata = rdata_r;
  assign o_ratio_err = err_r;

  // ----------------------------------------------------------------
  // colour filter position tracking
  // ----------------------------------------------------------------
  logic row_r;
  logic row_nxt;
  logic col_r;
  logic col_nxt;
  logic cur_row;
  logic cur_col;
  logic [1:0] chan_idx;

  always_comb
  begin
    cur_row = i_pix_sof ? 1'b0 : (i_pix_sol ? ~row_r : row_r);
    cur_col = (i_pix_sol || i_pix_sof) ? 1'b0 : col_r;
    row_nxt = row_r;
    col_nxt = col_r;
    if (i_pix_valid)
    begin
      row_nxt = cur_row;
      col_nxt = ~cur_col;
    end
    // rggb style mosaic, first row red/green or green/blue by strap
    if ((cur_row ^ ~i_cfa_row_rb) == 1'b0)
    begin
      chan_idx = cur_col ? 2'h1 : 2'h0;
    end
    else
    begin
      chan_idx = cur_col ? 2'h2 : 2'h1;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      row_r <= 1'b0;
      col_r <= 1'b0;
    end
    else if (i_ce)
    begin
      row_r <= row_nxt;
      col_r <= col_nxt;
    end
  end

  // ----------------------------------------------------------------
  // balance then shift, one register stage
  // ----------------------------------------------------------------
  logic [8:0] ratio_use;
  logic [20:0] prod;
  logic [13:0] scaled;
  logic [11:0] bal;
  logic [11:0] shf;
  logic sat;
  logic valid_r;
  logic valid_nxt;
  logic [11:0] pix_r;
  logic [11:0] pix_nxt;
  logic sat_r;
  logic sat_nxt;

  always_comb
  begin
    ratio_use = i_color_en ? ratio_r[chan_idx] : pbbs_pkg::RATIO_ONE;
    prod = 21'(i_pix_data) * 21'(ratio_use);
    scaled = 14'(prod / 21'(pbbs_pkg::FRAC_DIV));
    bal = (scaled > 14'(pbbs_pkg::PIX_FULL)) ? pbbs_pkg::PIX_FULL : scaled[11:0];
    sat = 1'b0;
    unique case (i_shift)
      3'h0: shf = bal;
      3'h1:
      begin
        shf = {bal[10:0], 1'b0};
        sat = bal[11];
      end
      3'h2:
      begin
        shf = {bal[9:0], 2'h0};
        sat = |bal[11:10];
      end
      3'h3:
      begin
        shf = {bal[8:0], 3'h0};
        sat = |bal[11:9];
      end
      3'h4:
      begin
        shf = {bal[7:0], 4'h0};
        sat = |bal[11:8];
      end
      default: shf = bal;
    endcase
    valid_nxt = i_pix_valid;
    pix_nxt = pix_r;
    sat_nxt = sat_r;
    if (i_pix_valid)
    begin
      pix_nxt = sat ? pbbs_pkg::PIX_FULL : shf;
      sat_nxt = sat;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      valid_r <= 1'b0;
      pix_r <= 12'h000;
      sat_r <= 1'b0;
    end
    else if (i_ce)
    begin
      valid_r <= valid_nxt;
      pix_r <= pix_nxt;
      sat_r <= sat_nxt;
    end
  end

  assign o_pix_valid = valid_r;
  assign o_pix_data = pix_r;
  assign o_pix_sat = sat_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);

  sequence s_pix_in_ce;
    i_ce && i_pix_valid;
  endsequence

  unity_pass_a: assert property (
    s_pix_in_ce && ratio_use == 9'h064 && i_shift == 3'h0 |=> o_pix_data == $past(i_pix_data))
    else $error("unity ratio changed pixel");
  shift_one_a: assert property (
    s_pix_in_ce && ratio_use == 9'h064 && i_shift == 3'h1 && !i_pix_data[11]
    |=> o_pix_data == {$past(i_pix_data[10:0]), 1'b0})
    else $error("shift one wrong bits");
  shift_four_a: assert property (
    s_pix_in_ce && ratio_use == 9'h064 && i_shift == 3'h4 && i_pix_data[11:8] == 4'h0
    |=> o_pix_data == {$past(i_pix_data[7:0]), 4'h0})
    else $error("shift four wrong bits");
  sat_two_a: assert property (
    s_pix_in_ce && ratio_use == 9'h064 && i_shift == 3'h2 && |i_pix_data[11:10]
    |=> o_pix_data == 12'hFFF && o_pix_sat)
    else $error("shift two no saturation");
  sat_three_a: assert property (
    s_pix_in_ce && ratio_use == 9'h064 && i_shift == 3'h3 && |i_pix_data[11:9]
    |=> o_pix_data == 12'hFFF)
    else $error("shift three no saturation");
  zero_ratio_a: assert property (
    s_pix_in_ce && ratio_use == 9'h000 && i_shift == 3'h0 |=> o_pix_data == 12'h000)
    else $error("zero ratio not zero");
  clamp_full_a: assert property (
    s_pix_in_ce && i_pix_data == 12'hFFF && ratio_use > 9'h064 && i_shift == 3'h0
    |=> o_pix_data == 12'hFFF)
    else $error("balance wrapped");
  reject_range_a: assert property (
    i_ce && i_ratio_wr && i_ratio_wdata > 9'h18E |=> o_ratio_err && $stable(ratio_r[0]))
    else $error("out of range ratio taken");
  ratio_store_a: assert property (
    i_ce && i_ratio_wr && i_ratio_sel == 2'h3 && i_ratio_wdata <= 9'h18E
    ##1 i_ce && i_ratio_sel == 2'h3 |=> o_ratio_rdata == $past(i_ratio_wdata, 2))
    else $error("blue ratio not stored");
  valid_follow_a: assert property (
    i_ce |=> o_pix_valid == $past(i_pix_valid))
    else $error("valid not one cycle late");

endmodule
`default_nettype wire

// File: common/pbbs_pkg.sv
// constants and types for the pixel balance and bit shift stage
`default_nettype none
package pbbs_pkg;
  localparam int unsigned ADC_W = 12;
  localparam int unsigned RATIO_W = 9;
  localparam int unsigned FRAC_DIV = 100;
  localparam logic [RATIO_W-1:0] RATIO_MAX = 9'h18E;
  localparam logic [RATIO_W-1:0] RATIO_ONE = 9'h064;
  localparam logic [ADC_W-1:0] PIX_FULL = 12'hFFF;
  localparam logic [2:0] SHIFT_MAX = 3'h4;
  localparam logic [1:0] CFA_PHASE_RST = 2'h0;
  typedef enum logic [1:0] {
    PBBS_CH_RED = 2'h0,
    PBBS_CH_GREEN = 2'h1,
    PBBS_CH_BLUE = 2'h3
  } pbbs_chan_t;
  typedef enum logic [1:0] {
    PBBS_ST_IDLE = 2'h0,
    PBBS_ST_RUN = 2'h1
  } pbbs_state_t;
endpackage
`default_nettype wire

// File: dv/pbbs_src.sv
// sensor sample stream model feeding the stage
`default_nettype none
module pbbs_src (
  output var logic o_valid,
  output var logic o_sol,
  output var logic o_sof,
  output var logic [11:0] o_data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    o_valid = 1'b0;
    o_sol = 1'b0;
    o_sof = 1'b0;
    o_data = 12'h0A5A;
  end
  // one converter sample with its line and frame marks
  task automatic put(input logic [11:0] d, input logic sol, input logic sof);
    o_valid = 1'b1;
    o_sol = sol;
    o_sof = sof;
    o_data = d;
  endtask
  // released bus shows inverted data
  task automatic idle();
    o_valid = 1'b0;
    o_sol = 1'b0;
    o_sof = 1'b0;
    o_data = ~o_data;
  endtask
endmodule
`default_nettype wire

// File: dv/tb_top.sv
// self-checking bench for the pixel balance and bit shift stage
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_sys_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic en = 1'b1;
  logic rowrb = 1'b1;
  logic wr = 1'b0;
  logic [1:0] sel = 2'h0;
  logic [8:0] wd = 9'h000;
  logic [2:0] sh = 3'h0;
  logic pv, sol, sof, err, ov, sat;
  logic [11:0] pd, od;
  logic [8:0] rd;
  int error_cnt = 0;
  int comparisons = 0;
  int ratio[4] = '{100, 100, 0, 100};
  int col, row, d;
  always #25 i_sys_clk = ~i_sys_clk;
  pbbs_src pbbs_src_inst (.o_valid(pv), .o_sol(sol), .o_sof(sof), .o_data(pd));
  pbbs_core pbbs_core_inst (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_ce(1'b1),
    .i_color_en(en), .i_cfa_row_rb(rowrb), .i_ratio_wr(wr), .i_ratio_sel(sel),
    .i_ratio_wdata(wd), .i_shift(sh), .i_pix_valid(pv), .i_pix_sol(sol),
    .i_pix_sof(sof), .i_pix_data(pd), .o_ratio_rdata(rd), .o_ratio_err(err),
    .o_pix_valid(ov), .o_pix_data(od), .o_pix_sat(sat));
  task automatic chk(input string nm, input logic [11:0] seen, input logic [11:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic step();
    @(posedge i_sys_clk);
    #5;
  endtask
  task automatic wr_ratio(input logic [1:0] s, input int v);
    bit ok;
    ok = (s != 2'h2) && (v <= 398);
    wr = 1'b1;
    sel = s;
    wd = 9'(v);
    step();
    wr = 1'b0;
    if (ok)
      ratio[s] = v;
    step();
    chk("ratio_err", {11'h000, err}, 12'(!ok));
    chk("ratio_rd", {3'h0, rd}, 12'(ratio[s]));
  endtask
  task automatic pix(input int dv, input bit fl, input bit ff);
    int ch, b, s, e, st;
    if (ff)
      row = 0;
    else if (fl)
      row ^= 1;
    if (fl)
      col = 0;
    ch = ((row == 0) == rowrb) ? (col ? 1 : 0) : (col ? 3 : 1);
    b = dv * (en ? ratio[ch] : 100) / 100;
    b = (b > 4095) ? 4095 : b;
    s = (sh > 4) ? 0 : int'(sh);
    st = (s > 0) && ((b >> (12 - s)) != 0);
    e = st ? 4095 : ((b << s) & 4095);
    pbbs_src_inst.put(12'(dv), fl, ff);
    step();
    col ^= 1;
    chk("pix_valid", {11'h000, ov}, 12'h001);
    chk("pix_data", od, 12'(e));
    chk("pix_sat", {11'h000, sat}, 12'(st));
  endtask
  // ----------------
  // stimulus
  // ----------------
  initial
  begin
    void'($urandom(25427));
    repeat (5) @(posedge i_sys_clk);
    #5;
    i_nrst = 1'b1;
    for (int c = 0; c < 4; c++)
    begin
      sel = 2'(c);
      step();
      chk("ratio_rst", {3'h0, rd}, 12'(ratio[c]));
    end
    wr_ratio(2'h2, 100);
    wr_ratio(2'h0, 399);
    wr_ratio(2'h0, 100);
    wr_ratio(2'h1, 398);
    wr_ratio(2'h3, 0);
    for (int f = 0; f < 14; f++)
    begin
      sh = 3'(f % 8);
      en = (f != 8);
      rowrb = 1'($urandom);
      if (f > 0)
        for (int c = 0; c < 4; c += (c == 1) ? 2 : 1)
          wr_ratio(2'(c), 100 + $urandom % 299);
      for (int l = 0; l < 3; l++)
      begin
        for (int p = 0; p < 4; p++)
        begin
          d = $urandom % (f[0] ? (4096 >> (sh % 5)) : 4096);
          pix(d, p == 0, l == 0 && p == 0);
        end
        pbbs_src_inst.idle();
        step();
        chk("pix_gap", {11'h000, ov}, 12'h000);
      end
    end
    end_sim();
  end
  initial
  begin
    #1000000;
    error_cnt++;
    end_sim();
  end
endmodule
`default_nettype wire
